// [inc/alt_report_pkg.sv]
// Shared constants and types for the serial altitude report generator.
package alt_report_pkg;

  // ==========================================================================
  // Clock and timing.
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_SLOW = 1200;
  localparam int BAUD_MID = 2400;
  localparam int BAUD_FAST = 9600;
  localparam int TONE_HZ = 1000;
  localparam int DIV_W = 17;
  localparam int DIV_1200 = (CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW;
  localparam int DIV_2400 = (CLK_HZ + BAUD_MID / 2) / BAUD_MID;
  localparam int DIV_9600 = (CLK_HZ + BAUD_FAST / 2) / BAUD_FAST;
  localparam int DIV_TONE = CLK_HZ / (2 * TONE_HZ);

  // ==========================================================================
  // Message layout.
  localparam int ALT_W = 18;
  localparam int MAG_W = 20;
  localparam logic [MAG_W-1:0] MAG_MAX = 20'h1869f;
  localparam logic [MAG_W-1:0] STEP_FINE = 20'h0000a;
  localparam logic [MAG_W-1:0] STEP_COARSE = 20'h00064;
  localparam logic [4:0] LAST_SUMMED = 5'h0d;
  localparam logic [4:0] LAST_IDX_SUM = 5'h10;
  localparam logic [4:0] LAST_IDX_ALT = 5'h09;
  localparam logic [3:0] DATA_BITS_LAST = 4'h7;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Characters.
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_TWO = 8'h32;
  localparam logic [7:0] CH_FIVE = 8'h35;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_HEX_AF = 8'h37;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    FMT_HASH = 2'b00,
    FMT_DOLLAR = 2'b01,
    FMT_ALT_MID = 2'b10,
    FMT_ALT_FAST = 2'b11
  } fmt_type;

  typedef struct packed {
    fmt_type fmt;
    logic [7:0] ch;
  } tx_word_type;

  localparam int WORD_W = $bits(tx_word_type);

endpackage

// [verilog/report_fifo.sv]
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module report_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // ==========================================================================
  // Full when pointers differ only in the wrap bit.
  assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [verilog/altitude_serial_reporter.sv]
// Serial altitude report generator: message builder, FIFO, UART transmitter, alarm tone.
// What this block does
// - Four message formats exist; only the selected one goes out the transmit line.
// - Reported altitude is rounded to 10 ft or 100 ft steps by setup.
// - Altitude reported is pressure altitude, independent of the pilot baro setting.
// - Format one at 1200 baud: #AL, space, sign, five digits, T+25, checksum, CR.
// - Format two at 1200 baud: $MGL, sign, five digits, T+25, checksum, CR.
// - Formats three (2400) and four (9600): ALT, space, five digits, CR.
// - Format select changes message structure and baud rate together.
// - Other functions work whether or not the serial output is used.
// - While alarm test is held, audio output sounds the alarm continuously.
`timescale 1ns/10ps
`default_nettype none
module altitude_serial_reporter
  import alt_report_pkg::*;
#(
  parameter logic [DIV_W-1:0] BAUD_DIV_1200 = DIV_W'(DIV_1200),
  parameter logic [DIV_W-1:0] BAUD_DIV_2400 = DIV_W'(DIV_2400),
  parameter logic [DIV_W-1:0] BAUD_DIV_9600 = DIV_W'(DIV_9600),
  parameter logic [DIV_W-1:0] TONE_HALF_DIV = DIV_W'(DIV_TONE)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic signed [ALT_W-1:0] pressure_alt,
  input wire logic report_req,
  input wire fmt_type format_select_key,
  input wire logic coarse_res,
  input wire logic alarm_request,
  input wire logic alarm_test_key,
  output logic encoder_tx,
  output logic audio_alert,
  output logic report_ready
);

  typedef enum logic [0:0] {
    BLD_IDLE = 1'b0,
    BLD_PUSH = 1'b1
  } bld_state_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } tx_state_type;

  // ==========================================================================
  // Helper functions.
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (CH_ZERO + {4'h0, nib}) : (CH_HEX_AF + {4'h0, nib});
  endfunction

  function automatic logic [DIV_W-1:0] baud_div(input fmt_type f);
    unique case (f)
      FMT_HASH, FMT_DOLLAR: baud_div = BAUD_DIV_1200;
      FMT_ALT_MID: baud_div = BAUD_DIV_2400;
      FMT_ALT_FAST: baud_div = BAUD_DIV_9600;
    endcase
  endfunction

  function automatic logic [7:0] char_at(input fmt_type f, input logic [4:0] idx, input logic neg,
                                         input logic [19:0] dig, input logic [7:0] sum);
    char_at = CH_CR;
    if (f == FMT_ALT_MID || f == FMT_ALT_FAST) begin
      unique case (idx)
        5'h00: char_at = CH_A;
        5'h01: char_at = CH_L;
        5'h02: char_at = CH_T;
        5'h03: char_at = CH_SPACE;
        5'h04: char_at = CH_ZERO | {4'h0, dig[19:16]};
        5'h05: char_at = CH_ZERO | {4'h0, dig[15:12]};
        5'h06: char_at = CH_ZERO | {4'h0, dig[11:8]};
        5'h07: char_at = CH_ZERO | {4'h0, dig[7:4]};
        5'h08: char_at = CH_ZERO | {4'h0, dig[3:0]};
        default: char_at = CH_CR;
      endcase
    end else begin
      unique case (idx)
        5'h00: char_at = (f == FMT_HASH) ? CH_HASH : CH_DOLLAR;
        5'h01: char_at = (f == FMT_HASH) ? CH_A : CH_M;
        5'h02: char_at = (f == FMT_HASH) ? CH_L : CH_G;
        5'h03: char_at = (f == FMT_HASH) ? CH_SPACE : CH_L;
        5'h04: char_at = neg ? CH_MINUS : CH_PLUS;
        5'h05: char_at = CH_ZERO | {4'h0, dig[19:16]};
        5'h06: char_at = CH_ZERO | {4'h0, dig[15:12]};
        5'h07: char_at = CH_ZERO | {4'h0, dig[11:8]};
        5'h08: char_at = CH_ZERO | {4'h0, dig[7:4]};
        5'h09: char_at = CH_ZERO | {4'h0, dig[3:0]};
        5'h0a: char_at = CH_T;
        5'h0b: char_at = CH_PLUS;
        5'h0c: char_at = CH_TWO;
        5'h0d: char_at = CH_FIVE;
        5'h0e: char_at = hex_char(sum[7:4]);
        5'h0f: char_at = hex_char(sum[3:0]);
        default: char_at = CH_CR;
      endcase
    end
  endfunction

  // ==========================================================================
  // Quantise and split the altitude into decimal digits.
  // The input is already referenced to standard pressure, so no baro term enters here.
  logic [MAG_W-1:0] mag;
  logic [MAG_W-1:0] step;
  logic [MAG_W-1:0] quant;
  logic [19:0] digits_d;

  always_comb begin
    mag = pressure_alt[ALT_W-1] ? MAG_W'(-pressure_alt) : MAG_W'(pressure_alt);
    step = coarse_res ? STEP_COARSE : STEP_FINE;
    quant = ((mag + (step >> 1)) / step) * step;
    if (quant > MAG_MAX) begin
      quant = MAG_MAX;
    end
    digits_d[19:16] = 4'((quant / 20'd10000) % 20'd10);
    digits_d[15:12] = 4'((quant / 20'd1000) % 20'd10);
    digits_d[11:8] = 4'((quant / 20'd100) % 20'd10);
    digits_d[7:4] = 4'((quant / 20'd10) % 20'd10);
    digits_d[3:0] = 4'(quant % 20'd10);
  end

  // ==========================================================================
  // Message builder.
  bld_state_type bld_q;
  fmt_type fmt_q;
  logic neg_q;
  logic [19:0] digits_q;
  logic [4:0] idx_q;
  logic [7:0] sum_q;
  tx_word_type push_word;
  logic push_ready;
  logic push_fire;
  logic [4:0] last_idx;

  assign last_idx = (fmt_q == FMT_HASH || fmt_q == FMT_DOLLAR) ? LAST_IDX_SUM : LAST_IDX_ALT;
  assign push_word.fmt = fmt_q;
  assign push_word.ch = char_at(fmt_q, idx_q, neg_q, digits_q, sum_q);
  assign push_fire = (bld_q == BLD_PUSH) && push_ready;

  // Format and value are frozen at request time so a mid-message change cannot mix layouts.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fmt_q <= FMT_HASH;
      neg_q <= 1'b0;
      digits_q <= '0;
    end else if (bld_q == BLD_IDLE && report_req) begin
      fmt_q <= format_select_key;
      neg_q <= pressure_alt[ALT_W-1] && (digits_d != '0);
      digits_q <= digits_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bld_q <= BLD_IDLE;
      idx_q <= '0;
      sum_q <= '0;
    end else begin
      unique case (bld_q)
        BLD_IDLE: begin
          idx_q <= '0;
          sum_q <= '0;
          if (report_req) begin
            bld_q <= BLD_PUSH;
          end
        end
        BLD_PUSH: begin
          if (push_fire) begin
            idx_q <= idx_q + 5'h01;
            if (idx_q <= LAST_SUMMED) begin
              sum_q <= sum_q + push_word.ch;
            end
            if (idx_q == last_idx) begin
              bld_q <= BLD_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      report_ready <= 1'b0;
    end else begin
      report_ready <= (bld_q == BLD_IDLE) && !report_req;
    end
  end

  // ==========================================================================
  // Character FIFO. The transmitter stalls the builder through push_ready.
  tx_word_type pop_word;
  logic pop_valid;
  logic pop_ready;

  report_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(push_word),
    .in_valid(bld_q == BLD_PUSH),
    .in_ready(push_ready),
    .out_data(pop_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready)
  );

  // ==========================================================================
  // Asynchronous transmitter, baud chosen per character.
  tx_state_type tx_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] cnt_q;
  logic tick;

  assign pop_ready = (tx_q == TX_IDLE);
  assign tick = (cnt_q == '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      div_q <= '0;
    end else if (tx_q == TX_IDLE && pop_valid) begin
      div_q <= baud_div(pop_word.fmt);
      cnt_q <= baud_div(pop_word.fmt) - 1'b1;
    end else if (tick) begin
      cnt_q <= div_q - 1'b1;
    end else begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_q <= TX_IDLE;
      shift_q <= '0;
      bit_q <= '0;
      encoder_tx <= 1'b1;
    end else begin
      unique case (tx_q)
        TX_IDLE: begin
          encoder_tx <= 1'b1;
          if (pop_valid) begin
            shift_q <= pop_word.ch;
            bit_q <= '0;
            encoder_tx <= 1'b0;
            tx_q <= TX_START;
          end
        end
        TX_START: begin
          if (tick) begin
            encoder_tx <= shift_q[0];
            shift_q <= shift_q >> 1;
            tx_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tick) begin
            if (bit_q == DATA_BITS_LAST) begin
              encoder_tx <= 1'b1;
              tx_q <= TX_STOP;
            end else begin
              encoder_tx <= shift_q[0];
              shift_q <= shift_q >> 1;
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            tx_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Alarm tone. It runs independently of the serial path, so an idle link never blocks it.
  logic [DIV_W-1:0] tone_cnt_q;
  logic tone_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tone_cnt_q <= '0;
      tone_q <= 1'b0;
    end else if (tone_cnt_q == '0) begin
      tone_cnt_q <= TONE_HALF_DIV - 1'b1;
      tone_q <= !tone_q;
    end else begin
      tone_cnt_q <= tone_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      audio_alert <= 1'b0;
    end else begin
      audio_alert <= (alarm_test_key || alarm_request) && tone_q;
    end
  end

endmodule
`default_nettype wire

// [verification/altitude_serial_reporter_properties.sv]
// Checker for the serial altitude report generator, bound to its ports.
`timescale 1ns/10ps
`default_nettype none
module altitude_serial_reporter_properties
  import alt_report_pkg::*;
#(
  parameter logic [DIV_W-1:0] BAUD_DIV_1200 = DIV_W'(DIV_1200),
  parameter logic [DIV_W-1:0] BAUD_DIV_2400 = DIV_W'(DIV_2400),
  parameter logic [DIV_W-1:0] BAUD_DIV_9600 = DIV_W'(DIV_9600),
  parameter logic [DIV_W-1:0] TONE_HALF_DIV = DIV_W'(DIV_TONE)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic signed [ALT_W-1:0] pressure_alt,
  input wire logic report_req,
  input wire fmt_type format_select_key,
  input wire logic coarse_res,
  input wire logic alarm_request,
  input wire logic alarm_test_key,
  input wire logic encoder_tx,
  input wire logic audio_alert,
  input wire logic report_ready
);
  // ==========================================================================
  // Helpers.
  // A high run longer than ten slow bit times means nothing is left in flight.
  int hi_q;
  int run_q;
  int held_q;
  logic aud_q;
  logic quiet;
  assign quiet = hi_q > 10 * int'(BAUD_DIV_1200);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) hi_q <= 0;
    else if (!encoder_tx) hi_q <= 0;
    else if (hi_q < 100000) hi_q <= hi_q + 1;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) aud_q <= 1'b0;
    else aud_q <= audio_alert;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) run_q <= 0;
    else run_q <= (audio_alert != aud_q) ? 1 : run_q + 1;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) held_q <= 0;
    else if (!alarm_test_key) held_q <= 0;
    else if (held_q < 100000) held_q <= held_q + 1;
  end
  // ==========================================================================
  // Properties.
  property p_reset_vals;
    @(posedge ref_clk) rst |-> encoder_tx && !audio_alert && !report_ready;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs wrong in reset");
  property p_ready_after;
    @(posedge ref_clk) disable iff (rst) $fell(rst) |=> report_ready;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("not ready after reset");
  property p_take;
    @(posedge ref_clk) disable iff (rst) report_req && report_ready |=> !report_ready;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_ready_keep;
    @(posedge ref_clk) disable iff (rst) report_ready && !report_req |=> report_ready;
  endproperty
  a_ready_keep: assert property (p_ready_keep) else $error("ready dropped alone");
  property p_ready_hold;
    @(posedge ref_clk) disable iff (rst) $fell(report_ready) |-> !report_ready [*8];
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("message pushed too fast");
  property p_start;
    @(posedge ref_clk) disable iff (rst)
      report_req && report_ready && quiet |-> encoder_tx ##1 encoder_tx ##1 encoder_tx ##1 !encoder_tx;
  endproperty
  a_start: assert property (p_start) else $error("start bit late or early");
  property p_quiet;
    @(posedge ref_clk) disable iff (rst)
      quiet && !report_req ##1 !report_req ##1 !report_req ##1 encoder_tx |=> encoder_tx;
  endproperty
  a_quiet: assert property (p_quiet) else $error("line left idle without request");
  property p_alarm_off;
    @(posedge ref_clk) disable iff (rst) !$past(alarm_request) && !$past(alarm_test_key) |-> !audio_alert;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm sounds unasked");
  property p_tone;
    @(posedge ref_clk) disable iff (rst) held_q > 2 * int'(TONE_HALF_DIV) + 4 |-> run_q <= int'(TONE_HALF_DIV);
  endproperty
  a_tone: assert property (p_tone) else $error("alarm tone stalled");
endmodule
bind altitude_serial_reporter altitude_serial_reporter_properties #(.BAUD_DIV_1200(BAUD_DIV_1200),
  .BAUD_DIV_2400(BAUD_DIV_2400), .BAUD_DIV_9600(BAUD_DIV_9600), .TONE_HALF_DIV(TONE_HALF_DIV)) chk (
  .ref_clk(ref_clk), .rst(rst), .pressure_alt(pressure_alt), .report_req(report_req),
  .format_select_key(format_select_key), .coarse_res(coarse_res), .alarm_request(alarm_request),
  .alarm_test_key(alarm_test_key), .encoder_tx(encoder_tx), .audio_alert(audio_alert),
  .report_ready(report_ready));
`default_nettype wire

// [verification/uart_listener.sv]
// Transponder serial input model: receives characters from the transmit line.
`timescale 1ns/10ps
`default_nettype none
module uart_listener (
  input wire logic ref_clk,
  input wire logic line,
  input wire logic [16:0] div
);
  // ==========================================================================
  // Receiver. Samples mid-bit, so a divider off by one still fails over ten bits.
  logic [7:0] rx_q[$];
  int frame_err = 0;
  logic [7:0] ch;
  initial begin
    forever begin
      @(posedge ref_clk);
      if (line === 1'b0) begin
        repeat (div / 2) @(posedge ref_clk);
        if (line !== 1'b0) frame_err++;
        for (int i = 0; i < 8; i++) begin
          repeat (div) @(posedge ref_clk);
          ch[i] = line;
        end
        repeat (div) @(posedge ref_clk);
        if (line !== 1'b1) frame_err++;
        rx_q.push_back(ch);
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb_altitude_serial_reporter.sv]
// Self-checking testbench for the serial altitude report generator.
`timescale 1ns/10ps
`default_nettype none
module tb_altitude_serial_reporter;
  import alt_report_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic signed [ALT_W-1:0] pressure_alt = '0;
  logic report_req = 1'b0;
  fmt_type format_select_key = FMT_HASH;
  logic coarse_res = 1'b0;
  logic alarm_request = 1'b0;
  logic alarm_test_key = 1'b0;
  logic encoder_tx;
  logic audio_alert;
  logic report_ready;
  logic [16:0] div = 17'h00010;
  int failures = 0;
  int checked = 0;
  always #4 ref_clk = ~ref_clk;
  altitude_serial_reporter #(.BAUD_DIV_1200(17'h00010), .BAUD_DIV_2400(17'h00008),
    .BAUD_DIV_9600(17'h00004), .TONE_HALF_DIV(17'h00004)) dut (
    .ref_clk(ref_clk), .rst(rst), .pressure_alt(pressure_alt), .report_req(report_req),
    .format_select_key(format_select_key), .coarse_res(coarse_res), .alarm_request(alarm_request),
    .alarm_test_key(alarm_test_key), .encoder_tx(encoder_tx), .audio_alert(audio_alert),
    .report_ready(report_ready));
  uart_listener partner (.ref_clk(ref_clk), .line(encoder_tx), .div(div));
  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] hex(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  task automatic req(input fmt_type f, input int alt, input bit c);
    for (int i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      if (report_ready === 1'b1) break;
    end
    #1;
    div = (f == FMT_ALT_FAST) ? 17'h00004 : (f == FMT_ALT_MID) ? 17'h00008 : 17'h00010;
    report_req = 1'b1;
    format_select_key = f;
    pressure_alt = ALT_W'(alt);
    coarse_res = c;
    @(posedge ref_clk);
    #1 report_req = 1'b0;
  endtask
  // Waits for reps copies of the expected message, then 400 more cycles, then compares.
  task automatic expect_msg(input fmt_type f, input int alt, input bit c, input int reps);
    logic [7:0] m[$];
    logic [7:0] sum;
    int q;
    int mag;
    mag = alt < 0 ? -alt : alt;
    q = (mag + (c ? 50 : 5)) / (c ? 100 : 10) * (c ? 100 : 10);
    if (q > 99999) q = 99999;
    if (f == FMT_HASH) m = {8'h23, 8'h41, 8'h4c, 8'h20};
    else if (f == FMT_DOLLAR) m = {8'h24, 8'h4d, 8'h47, 8'h4c};
    else m = {8'h41, 8'h4c, 8'h54, 8'h20};
    if (f == FMT_HASH || f == FMT_DOLLAR) m.push_back((alt < 0 && q != 0) ? 8'h2d : 8'h2b);
    for (int d = 10000; d > 0; d /= 10) m.push_back(8'h30 + 8'((q / d) % 10));
    if (f == FMT_HASH || f == FMT_DOLLAR) begin
      m = {m, 8'h54, 8'h2b, 8'h32, 8'h35};
      sum = 8'h00;
      foreach (m[i]) sum += m[i];
      m.push_back(hex(sum[7:4]));
      m.push_back(hex(sum[3:0]));
    end
    m.push_back(8'h0d);
    for (int i = 0; i < 9000 && partner.rx_q.size() < reps * m.size(); i++) @(posedge ref_clk);
    repeat (400) @(posedge ref_clk);
    check(partner.rx_q.size(), reps * m.size());
    check(partner.frame_err, 0);
    for (int i = 0; i < partner.rx_q.size() && i < reps * m.size(); i++) begin
      check(partner.rx_q[i], m[i % m.size()]);
    end
    partner.rx_q.delete();
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_formats();
    req(FMT_HASH, 5204, 1'b0);
    expect_msg(FMT_HASH, 5204, 1'b0, 1);
    req(FMT_DOLLAR, -1234, 1'b0);
    expect_msg(FMT_DOLLAR, -1234, 1'b0, 1);
    req(FMT_ALT_MID, 7, 1'b0);
    expect_msg(FMT_ALT_MID, 7, 1'b0, 1);
    req(FMT_ALT_FAST, 5260, 1'b1);
    expect_msg(FMT_ALT_FAST, 5260, 1'b1, 1);
  endtask
  task automatic t_rounding();
    req(FMT_HASH, -4, 1'b0);
    expect_msg(FMT_HASH, -4, 1'b0, 1);
    req(FMT_DOLLAR, 5249, 1'b1);
    expect_msg(FMT_DOLLAR, 5249, 1'b1, 1);
    req(FMT_HASH, 120000, 1'b0);
    expect_msg(FMT_HASH, 120000, 1'b0, 1);
  endtask
  // A request while building is dropped; the next one queues behind a full FIFO.
  task automatic t_refuse();
    req(FMT_HASH, 1000, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1 report_req = 1'b1;
    format_select_key = FMT_ALT_FAST;
    @(posedge ref_clk);
    #1 report_req = 1'b0;
    format_select_key = FMT_HASH;
    req(FMT_HASH, 1000, 1'b0);
    expect_msg(FMT_HASH, 1000, 1'b0, 2);
  endtask
  // The tone runs while a message is on the line, and the message stays intact.
  task automatic t_alarm(input bit use_test);
    int n;
    logic prev;
    req(FMT_ALT_FAST, 300, 1'b0);
    alarm_test_key = use_test;
    alarm_request = !use_test;
    repeat (12) @(posedge ref_clk);
    n = 0;
    prev = audio_alert;
    repeat (32) begin
      @(posedge ref_clk);
      if (audio_alert !== prev) n++;
      prev = audio_alert;
    end
    check(n, 8);
    #1 alarm_test_key = 1'b0;
    alarm_request = 1'b0;
    repeat (3) @(posedge ref_clk);
    n = 0;
    repeat (12) begin
      @(posedge ref_clk);
      if (audio_alert !== 1'b0) n++;
    end
    check(n, 0);
    expect_msg(FMT_ALT_FAST, 300, 1'b0, 1);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    test_done();
  end
  // Reset rises after time zero so every asynchronous reset branch sees a real edge.
  initial begin
    #1 rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_formats();
    t_rounding();
    t_refuse();
    t_alarm(1'b1);
    t_alarm(1'b0);
    test_done();
  end
endmodule
`default_nettype wire
